// *** hw/brt_timing.sv ***
// timing circuit: fixed rates, two counter/timers, two rate dividers
//
// Overview of operation
// - fixed rates come from the reference clock and scale with it.
// - one reference clock times every part of this block.
// - 27 fixed rates, 50 to 460.8K baud, all at once.
// - each fixed output runs at sixteen times its bit rate.
// - two 16-bit counter/timers; interrupt request at zero crossing.
// - counter/timer outputs go to channel clocks and to i/o pins.
// - four modes: character count, timer, counter, time-out.
// - division factor is high preset byte over low preset byte.
// - selected outputs are 16x clocks; channels divide by sixteen.
// - timer gives input over twice preset; pulse mode drops the two.
// - a preset of one is a legal divisor.
// - an input select chooses each counter/timer clock, except in character count mode.
// - each divider picks one of eight sources, with run control.
// - divider square wave: count preset high half, then low half.
// - divider outputs go to channel clocks and to i/o pins.
module brt_timing
    import brt_pkg::*;
#(
    parameter int N_RATES = NUM_RATES
)
(
    // clock and reset; sys_clk is reference_clock_in
    input wire logic sys_clk,
    input wire logic resetn,
    // external clock ticks, one cycle each
    input wire logic [1:0] ext_tick,
    // received character strobes per channel
    input wire logic [1:0] rx_char,
    // counter/timer control
    input wire brt_ct_req_type [1:0] ct_req,
    input wire brt_ct_cfg_type [1:0] ct_cfg,
    // programmable divider configuration
    input wire brt_div_cfg_type [1:0] div_cfg,
    // 16x clocks for receivers and transmitters
    output logic [N_RATES-1:0] rate_clk,
    output logic [1:0] ct_clk,
    output logic [1:0] div_clk,
    // counter/timer status
    output logic [1:0] ct_irq,
    output logic [1:0] ct_running,
    output logic [7:0] ct_rdata_0,
    output logic [7:0] ct_rdata_1
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [N_RATES-1:0][19:0] rcnt;
        logic [N_RATES-1:0] rlvl;
        logic [1:0][7:0] pre_lo;
        logic [1:0][7:0] pre_hi;
        logic [1:0][15:0] cnt;
        logic [1:0][1:0] st;
        logic [1:0] lvl;
        logic [1:0] irq;
        logic [1:0][7:0] rdat;
        logic [1:0] prev_src;
    } brt_top_st_type;

    brt_top_st_type st_q;
    brt_top_st_type st_d;

    logic [1:0] div_edge;
    logic [1:0] div_tick;
    logic [N_RATES-1:0] rate_edge;

    // ------------------------------------------------------------
    // source selection: 8 sources shared by dividers and timers
    // ------------------------------------------------------------
    // 0 reference, 1..2 external ticks, 3..4 counter/timers (dividers for timers),
    // 5..6 rate generator 16x edges (fastest two), 7 peer divider (none for timers)
    function automatic logic pick_src(input logic [2:0] s,
                                      input logic [1:0] ext,
                                      input logic [1:0] ctl,
                                      input logic [1:0] re,
                                      input logic peer);
        logic r;
        r = 1'b1;
        case (s)
            3'h0: r = 1'b1;
            3'h1: r = ext[0];
            3'h2: r = ext[1];
            3'h3: r = ctl[0];
            3'h4: r = ctl[1];
            3'h5: r = re[0];
            3'h6: r = re[1];
            3'h7: r = peer;
            default: r = 1'b1;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // programmable dividers
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_div
        // sources 3..4 take counter/timer rising edges, in the same cycle the counter/timer output rises
        assign div_tick[g] = pick_src(div_cfg[g].src, ext_tick,
            st_q.lvl & ~st_q.prev_src,
            rate_edge[N_RATES-1 -: 2], div_edge[1-g]);
        brt_divider u_div (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .run(div_cfg[g].run),
            .preset({div_cfg[g].preset_high, div_cfg[g].preset_low}),
            .tick(div_tick[g]),
            .clk_out(div_clk[g]),
            .edge_out(div_edge[g])
        );
    end

    // ------------------------------------------------------------
    // next state of rate generator and counter/timers
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] preset;
        logic tick;
        logic wrap;
        preset = 16'h0000;
        tick = 1'b0;
        wrap = 1'b0;
        st_d = st_q;
        rate_edge = '0;
        // a registered level toggles at most once a cycle, so the
        // fastest fixed output runs at half the reference
        // fixed generator: every output toggles on its own divisor
        for (int i = 0; i < N_RATES; i++) begin
            if (st_q.rcnt[i] >= (brt_rate_div(i) >> 1) - 20'h00001) begin
                st_d.rcnt[i] = 20'h00000;
                st_d.rlvl[i] = ~st_q.rlvl[i];
                rate_edge[i] = ~st_q.rlvl[i];
            end else begin
                st_d.rcnt[i] = st_q.rcnt[i] + 20'h00001;
            end
        end
        st_d.irq = '0;
        st_d.prev_src = st_q.lvl;
        for (int c = 0; c < 2; c++) begin
            preset = {st_q.pre_hi[c], st_q.pre_lo[c]};
            // command decode
            case (ct_req[c].cmd)
                CMD_START: begin
                    st_d.st[c] = ST_RUN;
                    st_d.cnt[c] = preset;
                end
                CMD_STOP: begin
                    st_d.st[c] = ST_STOP;
                    st_d.lvl[c] = OUT_RST;
                end
                CMD_WR_LOW: st_d.pre_lo[c] = ct_req[c].wdata;
                CMD_WR_HIGH: st_d.pre_hi[c] = ct_req[c].wdata;
                // reads return live count while running, preset if not
                CMD_RD_LOW: st_d.rdat[c] = (st_q.st[c] == ST_RUN) ?
                    st_q.cnt[c][7:0] : st_q.pre_lo[c];
                CMD_RD_HIGH: st_d.rdat[c] = (st_q.st[c] == ST_RUN) ?
                    st_q.cnt[c][15:8] : st_q.pre_hi[c];
                default: ;
            endcase
            // input clock: mode picks character strobes or selected tick
            case (ct_cfg[c].mode)
                CT_CHAR_COUNT: tick = rx_char[c];
                default: tick = pick_src(ct_cfg[c].src, ext_tick,
                    div_edge, rate_edge[N_RATES-1 -: 2], 1'b0);
            endcase
            // time-out restarts on every received character
            if (ct_cfg[c].mode == CT_TIMEOUT && rx_char[c] &&
                st_q.st[c] == ST_RUN) begin
                st_d.cnt[c] = preset;
            end else if (st_q.st[c] == ST_RUN && tick &&
                         ct_req[c].cmd != CMD_START &&
                         ct_req[c].cmd != CMD_STOP) begin
                wrap = st_q.cnt[c] <= 16'h0001;
                st_d.cnt[c] = brt_count(st_q.cnt[c], preset);
                if (wrap) begin
                    st_d.irq[c] = 1'b1;
                    case (ct_cfg[c].mode)
                        CT_TIMER: st_d.lvl[c] = ct_cfg[c].pulse ?
                            1'b1 : ~st_q.lvl[c];
                        CT_COUNTER: st_d.lvl[c] = 1'b1;
                        default: st_d.lvl[c] = ~st_q.lvl[c];
                    endcase
                end else if (ct_cfg[c].pulse &&
                             ct_cfg[c].mode == CT_TIMER) begin
                    st_d.lvl[c] = 1'b0; // one tick high per preset
                end
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.st <= {ST_STOP, ST_STOP};
            st_q.pre_lo <= {PRESET_RST[7:0], PRESET_RST[7:0]};
            st_q.pre_hi <= {PRESET_RST[15:8], PRESET_RST[15:8]};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs; channels divide these 16x clocks by sixteen
    // ------------------------------------------------------------
    assign rate_clk = st_q.rlvl;
    assign ct_clk = st_q.lvl;
    assign ct_irq = st_q.irq;
    assign ct_running = {st_q.st[1] == ST_RUN, st_q.st[0] == ST_RUN};
    assign ct_rdata_0 = st_q.rdat[0];
    assign ct_rdata_1 = st_q.rdat[1];

endmodule

// *** common/brt_pkg.sv ***
// package for the baud and counter/timer clock block
package brt_pkg;

    // ------------------------------------------------------------
    // reference and fixed rates
    // ------------------------------------------------------------
    localparam int REF_HZ = 14745600;   // nominal reference clock
    localparam int NUM_RATES = 27;      // fixed generator outputs
    localparam int OVERSAMPLE = 16;     // outputs are 16x bit rate
    localparam int RATE_W = 5;          // index width for 27 rates

    // ------------------------------------------------------------
    // counter/timer and divider fields
    // ------------------------------------------------------------
    localparam int PRESET_W = 16;
    localparam logic [15:0] PRESET_RST = 16'h0000;
    localparam logic [2:0] SRC_RST = 3'h0;
    localparam logic OUT_RST = 1'b0;    // output level while stopped

    // counter/timer modes
    typedef enum logic [1:0] {
        CT_CHAR_COUNT = 2'h0,
        CT_COUNTER = 2'h1,
        CT_TIMER = 2'h2,
        CT_TIMEOUT = 2'h3
    } brt_mode_type;

    // counter/timer commands
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_START = 3'h1,
        CMD_STOP = 3'h2,
        CMD_RD_LOW = 3'h3,
        CMD_WR_LOW = 3'h4,
        CMD_RD_HIGH = 3'h5,
        CMD_WR_HIGH = 3'h6
    } brt_cmd_type;

    // command bundle for one counter/timer
    typedef struct packed {
        brt_cmd_type cmd;
        logic [7:0] wdata;
    } brt_ct_req_type;

    // configuration of one counter/timer
    typedef struct packed {
        brt_mode_type mode;
        logic pulse;          // timer mode: pulse output instead of square wave
        logic [2:0] src;      // ct_input_select
    } brt_ct_cfg_type;

    // configuration of one programmable divider
    typedef struct packed {
        logic run;
        logic [2:0] src;
        logic [7:0] preset_low;
        logic [7:0] preset_high;
    } brt_div_cfg_type;

    // run states
    typedef enum logic [1:0] {
        ST_STOP = 2'b01,
        ST_RUN = 2'b10
    } brt_state_type;

    // table of fixed divisors of the reference for 16x outputs
    function automatic logic [19:0] brt_rate_div(input int idx);
        logic [19:0] t [27];
        t = '{20'h04800, 20'h02400, 20'h01800, 20'h01200, 20'h00FA2,
              20'h00D1A, 20'h00900, 20'h00600, 20'h00480, 20'h00300,
              20'h00240, 20'h00180, 20'h00120, 20'h000F0, 20'h000C0,
              20'h000A0, 20'h00090, 20'h00078, 20'h00060, 20'h00048,
              20'h00030, 20'h0001D, 20'h00018, 20'h0000C, 20'h00008,
              20'h00004, 20'h00002};
        return t[idx];
    endfunction

    // next count of a down counter that reloads at one
    function automatic logic [15:0] brt_count(
        input logic [15:0] cnt, input logic [15:0] preset);
        return (cnt <= 16'h0001) ? preset : cnt - 16'h0001;
    endfunction

endpackage

// *** hw/brt_divider.sv ***
// programmable rate divider: symmetric square wave of src/(2*preset)
module brt_divider
    import brt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // configuration
    input wire logic run,
    input wire logic [15:0] preset,
    // source tick, one cycle per source edge
    input wire logic tick,
    // outputs
    output logic clk_out,
    output logic edge_out
);

    typedef struct packed {
        logic [15:0] cnt;
        logic lvl;
        logic edg;
    } brt_div_st_type;

    brt_div_st_type st_q;
    brt_div_st_type st_d;

    // ------------------------------------------------------------
    // half period counting
    // ------------------------------------------------------------
    // a zero preset is treated as one so the divider never locks up
    always_comb begin
        st_d = st_q;
        st_d.edg = 1'b0;
        if (!run) begin
            st_d.cnt = 16'h0000;
            st_d.lvl = OUT_RST;
        end else if (tick) begin
            if (st_q.cnt <= 16'h0001) begin
                st_d.lvl = ~st_q.lvl;
                st_d.edg = ~st_q.lvl;
            end
            st_d.cnt = brt_count(st_q.cnt, preset);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign clk_out = st_q.lvl;
    assign edge_out = st_q.edg;

endmodule

// *** verif/brt_timing_assertions.sv ***
// concurrent checks on the ports of the timing block
module brt_timing_assertions
    import brt_pkg::*;
#(
    parameter int N_RATES = NUM_RATES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // stimulus side
    input wire logic [1:0] ext_tick,
    input wire logic [1:0] rx_char,
    input wire brt_ct_req_type [1:0] ct_req,
    input wire brt_ct_cfg_type [1:0] ct_cfg,
    input wire brt_div_cfg_type [1:0] div_cfg,
    // design outputs
    input wire logic [N_RATES-1:0] rate_clk,
    input wire logic [1:0] ct_clk,
    input wire logic [1:0] div_clk,
    input wire logic [1:0] ct_irq,
    input wire logic [1:0] ct_running,
    input wire logic [7:0] ct_rdata_0,
    input wire logic [7:0] ct_rdata_1
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // reset must quiet the counter/timers and dividers, so this one ignores the disable
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn |=> {ct_clk, div_clk, ct_irq, ct_running} == 8'h00)
        else $error("outputs not quiet after reset");
    a_start_runs: assert property (ct_req[0].cmd == CMD_START
        |=> ct_running[0]) else $error("start did not run");
    a_stop_halts: assert property (ct_req[1].cmd == CMD_STOP
        |=> !ct_running[1]) else $error("stop did not halt");
    a_rdata_hold: assert property (!(ct_req[0].cmd inside
        {CMD_RD_LOW, CMD_RD_HIGH}) |=> $stable(ct_rdata_0))
        else $error("read data moved without a read");
    a_irq_running: assert property (ct_irq[0]
        |-> $past(ct_running[0])) else $error("irq from idle unit");
    a_ct_hold: assert property (!ct_running[0] [*3]
        |-> $stable(ct_clk[0])) else $error("stopped c/t output moved");
    a_div_hold: assert property (!div_cfg[1].run [*3]
        |-> $stable(div_clk[1])) else $error("stopped divider moved");
    // preset of one on the reference halves every cycle
    a_div_fast: assert property ((div_cfg[1].run &&
        div_cfg[1].src == 3'h0 && div_cfg[1].preset_low == 8'h01 &&
        div_cfg[1].preset_high == 8'h00) [*5]
        |-> div_clk[1] != $past(div_clk[1]))
        else $error("divider by one not toggling");
endmodule

// *** verif/brt_rx_model.sv ***
// receiver-side model that times one selected 16x clock
module brt_rx_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // 16x clock under observation
    input wire logic clk_16x,
    // last period in reference cycles, edge and bit counts
    output logic [31:0] period,
    output logic [31:0] edges,
    output logic [31:0] bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt;
    logic last;

    // sampled on the reference, so only registered clocks are fair
    always @(posedge sys_clk) begin
        last <= clk_16x;
        if (!resetn) begin
            cnt <= 32'h0;
            edges <= 32'h0;
            bits <= 32'h0;
            period <= 32'h0;
        end else if (clk_16x && !last) begin
            period <= cnt + 32'h1;
            cnt <= 32'h0;
            edges <= edges + 32'h1;
            bits <= bits + {31'h0, edges[3:0] == 4'hF};
        end else begin
            cnt <= cnt + 32'h1;
        end
    end
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the timing block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import brt_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] ext_tick = 2'h0;
    logic [1:0] rx_char = 2'h0;
    brt_ct_req_type [1:0] ct_req = '0;
    brt_ct_cfg_type [1:0] ct_cfg = '0;
    brt_div_cfg_type [1:0] div_cfg = '0;
    logic [NUM_RATES-1:0] rate_clk;
    logic [1:0] ct_clk, div_clk, ct_irq, ct_running;
    logic [7:0] ct_rdata_0, ct_rdata_1;
    logic [31:0] period, edges, bits, b0;
    int mon_sel = 0;
    int err_count = 0;
    int n_checks = 0;
    int n = 0;
    int tdiv = 0;
    wire [32:0] all_clk = {ct_irq, div_clk, ct_clk, rate_clk};

    always #5 sys_clk = ~sys_clk;
    // external tick on line 0 every fourth cycle
    always @(negedge sys_clk) begin
        tdiv <= tdiv + 1;
        ext_tick <= {1'b0, tdiv % 4 == 3};
    end

    brt_timing #(.N_RATES(NUM_RATES)) i_dut (.sys_clk(sys_clk),
        .resetn(resetn), .ext_tick(ext_tick), .rx_char(rx_char),
        .ct_req(ct_req), .ct_cfg(ct_cfg), .div_cfg(div_cfg),
        .rate_clk(rate_clk), .ct_clk(ct_clk), .div_clk(div_clk),
        .ct_irq(ct_irq), .ct_running(ct_running),
        .ct_rdata_0(ct_rdata_0), .ct_rdata_1(ct_rdata_1));
    brt_rx_model i_rx (.sys_clk(sys_clk), .resetn(resetn),
        .clk_16x(all_clk[mon_sel]), .period(period), .edges(edges),
        .bits(bits));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one-cycle command, then an idle cycle
    task automatic ct_cmd(input int c, input brt_cmd_type k,
        input logic [7:0] d);
        @(negedge sys_clk);
        ct_req[c] = {k, d};
        @(negedge sys_clk);
        ct_req[c] = '0;
    endtask
    task automatic ct_run(input int c, input brt_mode_type m, input logic p,
        input logic [15:0] pre);
        ct_cmd(c, CMD_STOP, 8'h00);
        ct_cfg[c] = {m, p, 3'h0};
        ct_cmd(c, CMD_WR_LOW, pre[7:0]);
        ct_cmd(c, CMD_WR_HIGH, pre[15:8]);
        ct_cmd(c, CMD_START, 8'h00);
    endtask
    // stop first so the new preset starts from a clean count
    task automatic div_run(input int d, input logic [2:0] s,
        input logic [15:0] pre);
        @(negedge sys_clk);
        div_cfg[d] = {1'b0, s, pre[7:0], pre[15:8]};
        @(negedge sys_clk);
        div_cfg[d].run = 1'b1;
    endtask
    // skip the edge caused by switching the monitor, then time one
    task automatic meas(input int sel, input logic [31:0] exp);
        logic [31:0] e0;
        int w;
        mon_sel = sel;
        @(negedge sys_clk);
        e0 = edges;
        w = 0;
        while (edges - e0 < 32'h3 && w < 60000) begin
            @(negedge sys_clk);
            w++;
        end
        if (w == 60000) begin
            err_count++;
            wrap_up();
        end else begin
            check(period, exp);
        end
    endtask
    task automatic irq_count(input int c, input int cyc, input int every);
        n = 0;
        for (int i = 0; i < cyc; i++) begin
            @(negedge sys_clk);
            rx_char[c] = every > 0 && i % every == 0;
            if (ct_irq[c] === 1'b1) n++;
        end
        // let a pulse from the last step end before clearing
        @(negedge sys_clk);
        rx_char[c] = 1'b0;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        check({ct_clk, div_clk, ct_irq, ct_running}, 32'h0);
        meas(0, REF_HZ / (OVERSAMPLE * 50));
        div_run(1, 3'h0, 16'h0001);
        meas(30, 32'h2);
        // a steady period of two gives sixteen edges, one bit, per 32
        b0 = bits;
        repeat (32) @(negedge sys_clk);
        check(bits - b0, 32'h1);
        div_run(1, 3'h0, 16'h0003);
        meas(30, 32'h6);
        div_cfg[1].run = 1'b0;
        div_run(0, 3'h1, 16'h0002);
        meas(29, 32'h10);
        // divider 1 clocked by divider 0 edges: 16 cycles a tick
        div_run(1, 3'h7, 16'h0001);
        meas(30, 32'h20);
        ct_run(0, CT_TIMER, 1'b0, 16'h0102);
        meas(27, 32'h204);
        meas(31, 32'h102);
        ct_run(0, CT_TIMER, 1'b1, 16'h0102);
        meas(27, 32'h102);
        ct_run(1, CT_TIMER, 1'b0, 16'h0001);
        meas(28, 32'h2);
        check(ct_running, 32'h3);
        ct_cmd(1, CMD_STOP, 8'h00);
        ct_cmd(1, CMD_WR_LOW, 8'h5A);
        ct_cmd(1, CMD_WR_HIGH, 8'hA5);
        ct_cmd(1, CMD_RD_LOW, 8'h00);
        check(ct_rdata_1, 32'h5A);
        ct_cmd(1, CMD_RD_HIGH, 8'h00);
        check(ct_rdata_1, 32'hA5);
        // counter/timer 1 fed by divider 0, divider 1 fed by it in turn
        ct_run(1, CT_TIMER, 1'b0, 16'h0001);
        ct_cfg[1].src = 3'h3;
        meas(28, 32'h20);
        div_run(1, 3'h4, 16'h0001);
        meas(30, 32'h40);
        ct_run(0, CT_COUNTER, 1'b0, 16'h0004);
        repeat (12) @(negedge sys_clk);
        check(ct_clk[0], 32'h1);
        ct_run(1, CT_CHAR_COUNT, 1'b0, 16'h0003);
        irq_count(1, 12, 4);
        check(n, 32'h1);
        ct_run(0, CT_TIMEOUT, 1'b0, 16'h0008);
        irq_count(0, 24, 4);
        check(n, 32'h0);
        irq_count(0, 10, 0);
        check(n, 32'h1);
        ct_cmd(0, CMD_STOP, 8'h00);
        ct_cmd(0, CMD_RD_LOW, 8'h00);
        check(ct_rdata_0, 32'h08);
        wrap_up();
    end
endmodule

bind brt_timing brt_timing_assertions #(.N_RATES(N_RATES)) i_chk (
    .sys_clk(sys_clk), .resetn(resetn), .ext_tick(ext_tick),
    .rx_char(rx_char), .ct_req(ct_req), .ct_cfg(ct_cfg),
    .div_cfg(div_cfg), .rate_clk(rate_clk), .ct_clk(ct_clk),
    .div_clk(div_clk), .ct_irq(ct_irq), .ct_running(ct_running),
    .ct_rdata_0(ct_rdata_0), .ct_rdata_1(ct_rdata_1));
